// file: core/srp_pkg.sv
package srp_pkg;
   // Register offsets
   localparam logic [11:0] SOURCE_CONFIG_ADDR  = 12'h139;
   localparam logic [11:0] DIVIDER_HIGH_ADDR   = 12'h13a;
   localparam logic [11:0] DIVIDER_LOW_ADDR    = 12'h13b;
   localparam logic [11:0] DELAY_HIGH_ADDR     = 12'h13c;
   localparam logic [11:0] DELAY_LOW_ADDR      = 12'h13d;
   localparam logic [11:0] BURST_COUNT_ADDR    = 12'h13e;
   localparam logic [11:0] POWER_CONTROL_ADDR  = 12'h140;
   // Values after reset
   localparam logic [7:0]  SOURCE_CONFIG_RESET = 8'h00;
   localparam logic [7:0]  DIVIDER_HIGH_RESET  = 8'h0c;
   localparam logic [7:0]  DIVIDER_LOW_RESET   = 8'h00;
   localparam logic [7:0]  DELAY_HIGH_RESET    = 8'h00;
   localparam logic [7:0]  DELAY_LOW_RESET     = 8'h08;
   localparam logic [7:0]  BURST_COUNT_RESET   = 8'h03;
   localparam logic [7:0]  POWER_CONTROL_RESET = 8'h00;
   // Field positions
   localparam int REQ_ENABLE_BIT   = 4;
   localparam int SYNC_BYPASS_BIT  = 3;
   localparam int SOURCE_LSB       = 0;
   localparam int FRAME_PD_BIT     = 2;
   localparam int PULSER_PD_BIT    = 0;
   localparam int HIGH_FIELD_WIDTH = 5;
   // Smallest divide and delay values that are not reserved
   localparam logic [12:0] MIN_DIVIDE = 13'h0008;
   localparam logic [12:0] MIN_DELAY  = 13'h0008;

   // Source selection codes
   typedef enum logic [1:0] {
      SRC_NORMAL_SYNC = 2'b00,
      SRC_RECLOCKED   = 2'b01,
      SRC_PULSER      = 2'b10,
      SRC_CONTINUOUS  = 2'b11
   } srp_source_type;

   // Burst sequencer states
   typedef enum logic [0:0] {
      BURST_IDLE = 1'b0,
      BURST_RUN  = 1'b1
   } srp_burst_state_type;

   // Source configuration fields
   typedef struct packed {
      logic           request_pin_enable;
      logic           sync_bypass;
      srp_source_type frame_ref_source_select;
   } srp_cfg_type;
endpackage

// file: core/srp_divider.sv
`timescale 1ns/1ps
module srp_divider (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // Control
   input  wire logic        i_run,
   input  wire logic [12:0] i_divide,
   // Divider output
   output logic             o_start,
   output logic             o_high
);
   logic [12:0] count;
   logic [12:0] divide;
   logic [12:0] last;

   // Reserved small values are held at the smallest legal divide
   assign divide  = (i_divide < srp_pkg::MIN_DIVIDE) ? srp_pkg::MIN_DIVIDE : i_divide;
   assign last    = divide - 13'h0001;
   assign o_start = i_run && (count == 13'h0000);
   assign o_high  = i_run && (count < {1'b0, divide[12:1]});

   // Period counter, one output cycle per divide value
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || !i_run) begin
         count <= 13'h0000;
      end else if (count >= last) begin
         count <= 13'h0000;
      end else begin
         count <= count + 13'h0001;
      end
   end
endmodule

// file: core/srp_delay.sv
`timescale 1ns/1ps
module srp_delay (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // Control
   input  wire logic        i_restart,
   input  wire logic        i_enable,
   input  wire logic [12:0] i_delay,
   // Release of the divider
   output logic             o_release
);
   logic [12:0] remaining;

   assign o_release = i_enable && (remaining == 13'h0000);

   // Holds the divider off for the delay value after each restart
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || i_restart || !i_enable) begin
         remaining <= (i_delay < srp_pkg::MIN_DELAY) ? srp_pkg::MIN_DELAY : i_delay;
      end else if (remaining != 13'h0000) begin
         remaining <= remaining - 13'h0001;
      end
   end
endmodule

// file: core/srp_ctrl.sv
// Functional notes
// - Request enable lets the request pin force the continuous source.
// - Sync bypass skips polarity inversion; clear uses normal sync handling.
// - Bits 1:0 select normal sync, re-clocked, pulser or continuous.
// - Divider is 13 bits: high register low five bits, low register eight.
// - Divide values 8 to 8191 divide exactly; 0 to 7 reserved.
// - Delay is 13 bits split over high and low registers likewise.
// - Delay values 8 to 8191 delay exactly; 0 to 7 reserved.
// - Burst length has no effect while continuous source is selected.
// - Each burst register write launches a burst when pulser selected and powered.
// - Burst code 0,1,2,3 gives 1,2,4,8 pulses.
// - Frame reference power down stops divider, output and sync.
// - Pulser power down stops all bursts.
`timescale 1ns/1ps
module srp_ctrl (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // Register access
   input  wire logic [11:0] i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_rd,
   output logic [7:0]       o_reg_rdata,
   // Sync and request pin
   input  wire logic        i_sync_request_pin,
   input  wire logic        i_sync_polarity_invert,
   // Frame reference outputs
   output logic             o_frame_ref,
   output logic             o_sync_out,
   output logic             o_burst_busy
);
   // Registers
   srp_pkg::srp_cfg_type             source_config;
   logic [4:0]                       divider_high;
   logic [7:0]                       divider_low;
   logic [4:0]                       delay_high;
   logic [7:0]                       delay_low;
   logic [1:0]                       burst_length_code;
   logic                             frame_ref_power_down;
   logic                             pulser_power_down;
   // Pin synchroniser
   logic                             sync_meta;
   logic                             sync_q;
   // Burst sequencer
   srp_pkg::srp_burst_state_type     burst_state;
   srp_pkg::srp_burst_state_type     next_burst_state;
   logic [3:0]                       pulses_left;
   logic [3:0]                       next_pulses_left;
   logic                             in_pulse;
   logic                             next_in_pulse;
   logic                             reclocked;
   logic                             next_frame_ref;
   // Decode and datapath wires
   wire logic [12:0]                 frame_ref_divider;
   wire logic [12:0]                 frame_ref_digital_delay;
   wire srp_pkg::srp_source_type     eff_source;
   wire logic                        sync_proc;
   wire logic                        wr_config;
   wire logic                        wr_div_high;
   wire logic                        wr_div_low;
   wire logic                        wr_dly_high;
   wire logic                        wr_dly_low;
   wire logic                        wr_burst;
   wire logic                        wr_power;
   wire logic                        timing_restart;
   wire logic                        launch;
   wire logic                        burst_abort;
   wire logic                        div_run;
   wire logic                        div_start;
   wire logic                        div_high;
   wire logic [3:0]                  burst_pulses;
   wire logic [7:0]                  read_mux;
   wire srp_pkg::srp_cfg_type        cfg_written;
   wire srp_pkg::srp_cfg_type        cfg_reset;
   wire logic [12:0]                 next_frame_ref_delay;
   wire logic                        pulse_gate;

   // Write strobes per register
   assign wr_config   = i_reg_wr && (i_reg_addr == srp_pkg::SOURCE_CONFIG_ADDR);
   assign wr_div_high = i_reg_wr && (i_reg_addr == srp_pkg::DIVIDER_HIGH_ADDR);
   assign wr_div_low  = i_reg_wr && (i_reg_addr == srp_pkg::DIVIDER_LOW_ADDR);
   assign wr_dly_high = i_reg_wr && (i_reg_addr == srp_pkg::DELAY_HIGH_ADDR);
   assign wr_dly_low  = i_reg_wr && (i_reg_addr == srp_pkg::DELAY_LOW_ADDR);
   assign wr_burst    = i_reg_wr && (i_reg_addr == srp_pkg::BURST_COUNT_ADDR);
   assign wr_power    = i_reg_wr && (i_reg_addr == srp_pkg::POWER_CONTROL_ADDR);

   // Split fields joined into 13-bit values
   assign frame_ref_divider       = {divider_high, divider_low};
   assign frame_ref_digital_delay = {delay_high, delay_low};

   // Delay as it stands after this edge, so a restart loads a fresh write
   assign next_frame_ref_delay = {wr_dly_high ? i_reg_wdata[4:0] : delay_high,
                                  wr_dly_low  ? i_reg_wdata      : delay_low};

   // Source configuration fields picked by position, bit 2 stays reserved
   assign cfg_written = {i_reg_wdata[srp_pkg::REQ_ENABLE_BIT],
                         i_reg_wdata[srp_pkg::SYNC_BYPASS_BIT],
                         i_reg_wdata[srp_pkg::SOURCE_LSB +: 2]};
   assign cfg_reset   = {srp_pkg::SOURCE_CONFIG_RESET[srp_pkg::REQ_ENABLE_BIT],
                         srp_pkg::SOURCE_CONFIG_RESET[srp_pkg::SYNC_BYPASS_BIT],
                         srp_pkg::SOURCE_CONFIG_RESET[srp_pkg::SOURCE_LSB +: 2]};

   // Register file
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         source_config        <= cfg_reset;
         divider_high         <= srp_pkg::DIVIDER_HIGH_RESET[4:0];
         divider_low          <= srp_pkg::DIVIDER_LOW_RESET;
         delay_high           <= srp_pkg::DELAY_HIGH_RESET[4:0];
         delay_low            <= srp_pkg::DELAY_LOW_RESET;
         burst_length_code    <= srp_pkg::BURST_COUNT_RESET[1:0];
         frame_ref_power_down <= srp_pkg::POWER_CONTROL_RESET[srp_pkg::FRAME_PD_BIT];
         pulser_power_down    <= srp_pkg::POWER_CONTROL_RESET[srp_pkg::PULSER_PD_BIT];
      end else begin
         if (wr_config) begin
            source_config <= cfg_written;
         end
         if (wr_div_high) begin
            divider_high <= i_reg_wdata[4:0];
         end
         if (wr_div_low) begin
            divider_low <= i_reg_wdata;
         end
         if (wr_dly_high) begin
            delay_high <= i_reg_wdata[4:0];
         end
         if (wr_dly_low) begin
            delay_low <= i_reg_wdata;
         end
         if (wr_burst) begin
            burst_length_code <= i_reg_wdata[1:0];
         end
         if (wr_power) begin
            frame_ref_power_down <= i_reg_wdata[srp_pkg::FRAME_PD_BIT];
            pulser_power_down    <= i_reg_wdata[srp_pkg::PULSER_PD_BIT];
         end
      end
   end

   // Read selection, reserved bits and unmapped offsets read zero
   assign read_mux =
      (i_reg_addr == srp_pkg::SOURCE_CONFIG_ADDR) ? {3'h0, source_config[3:2], 1'b0,
                                                     source_config[1:0]} :
      (i_reg_addr == srp_pkg::DIVIDER_HIGH_ADDR)  ? {3'h0, divider_high} :
      (i_reg_addr == srp_pkg::DIVIDER_LOW_ADDR)   ? divider_low :
      (i_reg_addr == srp_pkg::DELAY_HIGH_ADDR)    ? {3'h0, delay_high} :
      (i_reg_addr == srp_pkg::DELAY_LOW_ADDR)     ? delay_low :
      (i_reg_addr == srp_pkg::BURST_COUNT_ADDR)   ? {6'h00, burst_length_code} :
      (i_reg_addr == srp_pkg::POWER_CONTROL_ADDR) ?
         {5'h00, frame_ref_power_down, 1'b0, pulser_power_down} : 8'h00;

   // Read data register
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         o_reg_rdata <= read_mux;
      end
   end

   // Two-stage synchroniser for the request pin
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         sync_meta <= 1'b0;
         sync_q    <= 1'b0;
      end else begin
         sync_meta <= i_sync_request_pin;
         sync_q    <= sync_meta;
      end
   end

   // Sync path, polarity stage skipped when bypassed
   assign sync_proc = source_config.sync_bypass ? sync_q
                                                : (sync_q ^ i_sync_polarity_invert);

   // Pin request overrides the programmed source
   assign eff_source = (source_config.request_pin_enable && sync_q)
                       ? srp_pkg::SRC_CONTINUOUS
                       : source_config.frame_ref_source_select;

   // Divider timing, restarted by any divide or delay change
   assign timing_restart = wr_div_high || wr_div_low || wr_dly_high || wr_dly_low;

   srp_delay u_delay (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_restart (timing_restart),
      .i_enable  (!frame_ref_power_down),
      .i_delay   (next_frame_ref_delay),
      .o_release (div_run)
   );

   srp_divider u_divider (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_run     (div_run),
      .i_divide  (frame_ref_divider),
      .o_start   (div_start),
      .o_high    (div_high)
   );

   // Burst launch and abort conditions
   assign burst_pulses = 4'h1 << i_reg_wdata[1:0];
   assign launch       = wr_burst && (eff_source == srp_pkg::SRC_PULSER)
                         && !frame_ref_power_down && !pulser_power_down;
   assign burst_abort  = frame_ref_power_down || pulser_power_down
                         || (eff_source != srp_pkg::SRC_PULSER);

   // Pulse window opens at a start with pulses left, closes at the empty start
   assign pulse_gate = div_start
                       ? ((burst_state == srp_pkg::BURST_RUN) && (pulses_left != 4'h0))
                       : in_pulse;

   // Burst sequencer next state
   always_comb begin
      next_burst_state = burst_state;
      next_pulses_left = pulses_left;
      next_in_pulse    = in_pulse;
      case (burst_state)
         srp_pkg::BURST_IDLE: begin
            next_in_pulse = 1'b0;
            if (launch) begin
               next_pulses_left = burst_pulses;
               next_burst_state = srp_pkg::BURST_RUN;
            end
         end
         srp_pkg::BURST_RUN: begin
            if (burst_abort) begin
               next_in_pulse    = 1'b0;
               next_pulses_left = 4'h0;
               next_burst_state = srp_pkg::BURST_IDLE;
            end else if (launch) begin
               next_pulses_left = burst_pulses;
            end else if (div_start) begin
               if (pulses_left != 4'h0) begin
                  next_in_pulse    = 1'b1;
                  next_pulses_left = pulses_left - 4'h1;
               end else begin
                  next_in_pulse    = 1'b0;
                  next_burst_state = srp_pkg::BURST_IDLE;
               end
            end
         end
         default: begin
            next_in_pulse    = 1'b0;
            next_pulses_left = 4'h0;
            next_burst_state = srp_pkg::BURST_IDLE;
         end
      endcase
   end

   // Output selection by effective source
   always_comb begin
      next_frame_ref = 1'b0;
      if (!frame_ref_power_down) begin
         case (eff_source)
            srp_pkg::SRC_NORMAL_SYNC: next_frame_ref = sync_proc;
            srp_pkg::SRC_RECLOCKED:   next_frame_ref = reclocked;
            srp_pkg::SRC_PULSER:      next_frame_ref = pulse_gate && div_high;
            srp_pkg::SRC_CONTINUOUS:  next_frame_ref = div_high;
            default:                  next_frame_ref = 1'b0;
         endcase
      end
   end

   // Sequencer, re-clock stage and output flops
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         burst_state  <= srp_pkg::BURST_IDLE;
         pulses_left  <= 4'h0;
         in_pulse     <= 1'b0;
         reclocked    <= 1'b0;
         o_frame_ref  <= 1'b0;
         o_sync_out   <= 1'b0;
         o_burst_busy <= 1'b0;
      end else begin
         burst_state  <= next_burst_state;
         pulses_left  <= next_pulses_left;
         in_pulse     <= next_in_pulse;
         if (div_start) begin
            reclocked <= sync_proc;
         end
         o_frame_ref  <= next_frame_ref;
         o_sync_out   <= sync_proc && !frame_ref_power_down;
         o_burst_busy <= (next_burst_state == srp_pkg::BURST_RUN);
      end
   end

   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence s_launch;
      launch && !burst_abort;
   endsequence

   sequence s_loaded;
      ##1 (pulses_left == $past(burst_pulses));
   endsequence

   a_pd_quiet: assert property (frame_ref_power_down |=> !o_frame_ref && !o_sync_out)
      else $error("output active while powered down");

   a_req_force: assert property (
      source_config.request_pin_enable && sync_q && !frame_ref_power_down
      |=> o_frame_ref == $past(div_high))
      else $error("request pin did not force continuous output");

   a_bypass_path: assert property (
      source_config.sync_bypass && !frame_ref_power_down
      && eff_source == srp_pkg::SRC_NORMAL_SYNC |=> o_frame_ref == $past(sync_q))
      else $error("bypassed sync not passed straight");

   a_div_spacing: assert property (div_start |=> !div_start [*7])
      else $error("divider period shorter than eight");

   a_delay_hold: assert property (timing_restart && !frame_ref_power_down
      |=> !div_run [*7])
      else $error("divider released before delay");

   a_burst_load: assert property (s_launch |-> s_loaded)
      else $error("burst length not loaded from code");

   a_burst_start: assert property (s_launch |=> burst_state == srp_pkg::BURST_RUN)
      else $error("burst not launched on write");

   a_pulser_off: assert property (pulser_power_down |=> !in_pulse && !o_burst_busy)
      else $error("pulse produced with pulser powered down");

   a_cont_rate: assert property (
      eff_source == srp_pkg::SRC_CONTINUOUS && !frame_ref_power_down
      |=> o_frame_ref == $past(div_high))
      else $error("continuous output not at divider rate");

   a_field_join: assert property (wr_div_low |=> frame_ref_divider[7:0] == $past(i_reg_wdata))
      else $error("divider low field not stored");
endmodule

// file: verification/srp_frame_ref_rx.sv
`timescale 1ns/1ps
module srp_frame_ref_rx (
   // Clock and control
   input  wire logic        i_ref_clk,
   input  wire logic        i_clear,
   // Frame reference from the device
   input  wire logic        i_frame_ref,
   // Measurements
   output logic [15:0]      o_edges,
   output logic [15:0]      o_period,
   output logic [15:0]      o_high,
   output logic [15:0]      o_first
);
   logic        last_ref;
   logic [15:0] since_rise;
   logic [15:0] since_clear;
   logic [15:0] high_run;

   // Receiver view: edge count, edge spacing, high width, first edge time
   always @(posedge i_ref_clk) begin
      last_ref <= i_frame_ref;
      since_rise <= since_rise + 16'h0001;
      since_clear <= since_clear + 16'h0001;
      high_run <= i_frame_ref ? high_run + 16'h0001 : 16'h0000;
      if (!i_frame_ref && last_ref) begin
         o_high <= high_run;
      end
      if (i_clear) begin
         o_edges <= 16'h0000;
         since_clear <= 16'h0000;
         o_first <= 16'hffff;
      end else if (i_frame_ref && !last_ref) begin
         o_edges <= o_edges + 16'h0001;
         o_period <= since_rise;
         since_rise <= 16'h0001;
         if (o_edges == 16'h0000) begin
            o_first <= since_clear;
         end
      end
   end
endmodule

// file: verification/srp_ctrl_tb.sv
`timescale 1ns/1ps
module srp_ctrl_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic        reg_wr = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic        pin = 1'b0;
   logic        pol_inv = 1'b0;
   logic        frame_ref;
   logic        sync_out;
   logic        busy;
   logic        rx_clear = 1'b1;
   logic [15:0] edges;
   logic [15:0] period;
   logic [15:0] high;
   logic [15:0] first;
   logic [31:0] rnd = 32'h0daa_36d4;
   int          fails = 0;
   int          cmp_count = 0;

   // 25 MHz reference clock
   always #20 clk = ~clk;

   srp_ctrl srp_ctrl_inst (
      .i_ref_clk              (clk),
      .i_rst                  (rst),
      .i_reg_addr             (reg_addr),
      .i_reg_wr               (reg_wr),
      .i_reg_wdata            (reg_wdata),
      .i_reg_rd               (reg_rd),
      .o_reg_rdata            (reg_rdata),
      .i_sync_request_pin     (pin),
      .i_sync_polarity_invert (pol_inv),
      .o_frame_ref            (frame_ref),
      .o_sync_out             (sync_out),
      .o_burst_busy           (busy)
   );

   srp_frame_ref_rx srp_frame_ref_rx_inst (
      .i_ref_clk   (clk),
      .i_clear     (rx_clear),
      .i_frame_ref (frame_ref),
      .o_edges     (edges),
      .o_period    (period),
      .o_high      (high),
      .o_first     (first)
   );

   // Repeatable pseudo-random source
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // Expected period: reserved values behave as the smallest divide
   function automatic logic [15:0] exp_period(input logic [12:0] d);
      return (d < 13'h0008) ? 16'h0008 : {3'b000, d};
   endfunction

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic set_divide(input logic [12:0] d);
      reg_write(srp_pkg::DIVIDER_HIGH_ADDR, {3'b000, d[12:8]});
      reg_write(srp_pkg::DIVIDER_LOW_ADDR, d[7:0]);
   endtask

   task automatic rx_reset;
      @(posedge clk);
      rx_clear <= 1'b1;
      @(posedge clk);
      rx_clear <= 1'b0;
   endtask

   // Watchdog sized well above the expected run
   initial begin
      tick(40000);
      fails++;
      test_done();
   end

   // Main sequence
   initial begin
      logic [11:0] adr [7];
      logic [7:0]  rv [7];
      logic [7:0]  msk [7];
      logic [7:0]  d;
      logic [12:0] div;
      logic [1:0]  code;
      adr = '{12'h139, 12'h13a, 12'h13b, 12'h13c, 12'h13d, 12'h13e, 12'h140};
      rv = '{8'h00, 8'h0c, 8'h00, 8'h00, 8'h08, 8'h03, 8'h00};
      msk = '{8'h1b, 8'h1f, 8'hff, 8'h1f, 8'hff, 8'h03, 8'h05};
      tick(10);
      rst <= 1'b0;
      rx_clear <= 1'b0;
      // Reset values, writable bits, unmapped place
      for (int i = 0; i < 7; i++) begin
         reg_read(adr[i], d);
         check("reset value", {8'h00, d}, {8'h00, rv[i]});
         reg_write(adr[i], 8'hff);
         reg_read(adr[i], d);
         check("writable bits", {8'h00, d}, {8'h00, msk[i]});
         reg_write(adr[i], rv[i]);
      end
      reg_read(12'h141, d);
      check("unmapped read", {8'h00, d}, 16'h0000);
      $display("test registers done");
      // Sync polarity handling and bypass
      pol_inv <= 1'b1;
      pin <= 1'b1;
      tick(8);
      check("sync inverted", {15'h0000, sync_out}, 16'h0000);
      check("normal sync source", {15'h0000, frame_ref}, 16'h0000);
      reg_write(srp_pkg::SOURCE_CONFIG_ADDR, 8'h08);
      tick(8);
      check("sync bypassed", {15'h0000, sync_out}, 16'h0001);
      check("bypass source", {15'h0000, frame_ref}, 16'h0001);
      pin <= 1'b0;
      pol_inv <= 1'b0;
      $display("test sync done");
      // Continuous output period and width, reserved divide first
      reg_write(srp_pkg::SOURCE_CONFIG_ADDR, 8'h03);
      for (int i = 0; i < 4; i++) begin
         rnd = xs(rnd);
         div = (i == 0) ? 13'h0005 : 13'h0008 + {8'h00, rnd[4:0]};
         set_divide(div);
         tick(60);
         rx_reset();
         tick(3 * exp_period(div) + 4);
         check("period", period, exp_period(div));
         check("high width", high, exp_period(div) >> 1);
      end
      // Delay from restart to first edge
      set_divide(13'h0008);
      reg_write(srp_pkg::DELAY_HIGH_ADDR, 8'h00);
      rx_reset();
      reg_write(srp_pkg::DELAY_LOW_ADDR, 8'h28);
      tick(80);
      check("delay floor", {15'h0000, first >= 16'h0028}, 16'h0001);
      check("delay ceiling", {15'h0000, first <= 16'h0032}, 16'h0001);
      // Re-clocked source follows the pin at divider starts
      reg_write(srp_pkg::SOURCE_CONFIG_ADDR, 8'h01);
      pin <= 1'b1;
      tick(20);
      check("reclocked high", {15'h0000, frame_ref}, 16'h0001);
      pin <= 1'b0;
      tick(20);
      check("reclocked low", {15'h0000, frame_ref}, 16'h0000);
      $display("test continuous done");
      // Bursts of every length, plus a random code
      reg_write(srp_pkg::SOURCE_CONFIG_ADDR, 8'h02);
      for (int i = 0; i < 5; i++) begin
         rnd = xs(rnd);
         code = (i < 4) ? i[1:0] : rnd[1:0];
         rx_reset();
         reg_write(srp_pkg::BURST_COUNT_ADDR, {6'h00, code});
         tick(2);
         check("burst busy", {15'h0000, busy}, 16'h0001);
         for (int k = 0; k < 400 && busy !== 1'b0; k++) begin
            @(posedge clk);
         end
         tick(12);
         check("burst pulses", edges, 16'h0001 << code);
      end
      $display("test bursts done");
      // Pulse count ignored while continuous
      reg_write(srp_pkg::SOURCE_CONFIG_ADDR, 8'h03);
      reg_write(srp_pkg::BURST_COUNT_ADDR, 8'h01);
      tick(3);
      check("no burst when continuous", {15'h0000, busy}, 16'h0000);
      // Frame reference power down
      reg_write(srp_pkg::POWER_CONTROL_ADDR, 8'h04);
      tick(4);
      rx_reset();
      tick(50);
      check("powered down edges", edges, 16'h0000);
      check("powered down sync", {15'h0000, sync_out}, 16'h0000);
      // Pulser power down
      reg_write(srp_pkg::POWER_CONTROL_ADDR, 8'h01);
      reg_write(srp_pkg::SOURCE_CONFIG_ADDR, 8'h02);
      rx_reset();
      reg_write(srp_pkg::BURST_COUNT_ADDR, 8'h00);
      tick(50);
      check("pulser off edges", edges, 16'h0000);
      check("pulser off busy", {15'h0000, busy}, 16'h0000);
      reg_write(srp_pkg::POWER_CONTROL_ADDR, 8'h00);
      $display("test power down done");
      // Request pin forces continuous output
      reg_write(srp_pkg::SOURCE_CONFIG_ADDR, 8'h12);
      pin <= 1'b1;
      tick(40);
      rx_reset();
      tick(28);
      check("requested edges", {15'h0000, edges >= 16'h0003}, 16'h0001);
      check("requested period", period, 16'h0008);
      pin <= 1'b0;
      tick(40);
      rx_reset();
      tick(28);
      check("request released", edges, 16'h0000);
      $display("test request pin done");
      test_done();
   end
endmodule
